// ---- pkg/clt_pkg.sv ----
// Behaviour
// - three tables, 256 entries of 8 bits
// - writes to red_table_port-blue_table_port fill red/green/blue tables in programming mode only
// - bytes advance entry; each packet restarts at pointer
// - zero byte count means a 256-byte block
// - reads return table data from the pointer onward in programming mode, 0x00 otherwise
// - translation off after reset, sleep or power-down
// - only enabled colours translate, others pass through
// - component value indexes its table; entry replaces it
// - low and upper colour bits on fixed output bits
// - syncs and data enable on bits 18-20, untranslated
// - 3-channel mode indexes only entries 0x00-0x3F
package clt_pkg;

  // Register addresses on the control channel.
  localparam logic [7:0] ADDR_CONTROL = 8'h7C;
  localparam logic [7:0] ADDR_RED = 8'h7D;
  localparam logic [7:0] ADDR_GREEN = 8'h7E;
  localparam logic [7:0] ADDR_BLUE = 8'h7F;

  // Field positions and reset value of the control register.
  localparam int BIT_PROGRAM = 3;
  localparam int BIT_BLUE_ON = 2;
  localparam int BIT_GREEN_ON = 1;
  localparam int BIT_RED_ON = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Table and output geometry.
  localparam int TABLE_DEPTH = 256;
  localparam int TABLE_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int PIXEL_OUT_WIDTH = 27;
  localparam logic [7:0] NARROW_INDEX_MASK = 8'h3F;

  // Output bit positions of the pixel word.
  localparam int OUT_GREEN_LOW = 6;
  localparam int OUT_BLUE_LOW = 12;
  localparam int OUT_HSYNC = 18;
  localparam int OUT_VSYNC = 19;
  localparam int OUT_DATA_ENABLE = 20;
  localparam int OUT_RED_HIGH = 21;
  localparam int OUT_GREEN_HIGH = 23;
  localparam int OUT_BLUE_HIGH = 25;

  // Bus width select encodings.
  localparam logic [1:0] WIDTH_THREE_CHANNEL = 2'h0;
  localparam logic [1:0] WIDTH_FOUR_CHANNEL = 2'h1;
  localparam logic [1:0] WIDTH_HIGH_BANDWIDTH = 2'h2;

  typedef enum logic [1:0] {
    PKT_IDLE = 2'b00,
    PKT_WRITE = 2'b01,
    PKT_READ = 2'b10
  } clt_packet_e;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic hsync;
    logic vsync;
    logic dataEnable;
  } clt_pixel_s;

  typedef struct packed {
    logic start;
    logic write;
    logic [7:0] regAddress;
  } clt_packet_s;

  typedef struct packed {
    logic enable;
    logic [7:0] index;
    logic [7:0] data;
  } clt_table_write_s;

endpackage : clt_pkg

// ---- core/clt_table.sv ----
`timescale 1ns/10ps
// One colour table with a write port and two flop-read ports.
module clt_table (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire clt_pkg::clt_table_write_s tableWrite,
  input wire logic [7:0] lookIndex,
  output logic [7:0] lookData,
  input wire logic [7:0] readIndex,
  output logic [7:0] readData
);

  typedef struct packed {
    logic [clt_pkg::TABLE_DEPTH-1:0][clt_pkg::TABLE_WIDTH-1:0] entry;
  } clt_table_state_s;

  clt_table_state_s s;
  clt_table_state_s next_s;

  // Contents carry no meaning after reset; clearing keeps unknown
  // values out of the pixel path.
  always_comb begin
    next_s = s;
    if (tableWrite.enable) begin
      next_s.entry[tableWrite.index] = tableWrite.data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Both read ports see stored flops only.
  assign lookData = s.entry[lookIndex];
  assign readData = s.entry[readIndex];

endmodule : clt_table

// ---- core/clt_fifo.sv ----
`timescale 1ns/10ps
// Small flop FIFO with valid and ready on both sides.
module clt_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] head;
    logic [PW-1:0] tail;
    logic [PW:0] count;
  } clt_fifo_state_s;

  clt_fifo_state_s s;
  clt_fifo_state_s next_s;
  logic push;
  logic pop;

  // Full and empty follow the count, so ready drops only when full.
  assign inReady = (s.count != DEPTH[PW:0]);
  assign outValid = (s.count != '0);
  assign outData = s.mem[s.head];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.tail] = inData;
      next_s.tail = s.tail + 1'b1;
    end
    if (pop) begin
      next_s.head = s.head + 1'b1;
    end
    case ({push, pop})
      2'b10: next_s.count = s.count + 1'b1;
      2'b01: next_s.count = s.count - 1'b1;
      default: next_s.count = s.count;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : clt_fifo

// ---- core/color_lookup_translation.sv ----
`timescale 1ns/10ps
// Colour lookup translation stage on the parallel pixel path.
module color_lookup_translation (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic sleepMode,
  input wire logic [1:0] busWidthSelect,
  input wire logic [7:0] tableStartPointer,
  input wire clt_pkg::clt_packet_s packetStart,
  input wire logic packetEnd,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic readRequest,
  output logic readValid,
  output logic [7:0] readData,
  output logic [7:0] controlValue,
  input wire clt_pkg::clt_pixel_s pixelIn,
  input wire logic pixelInValid,
  output logic pixelInReady,
  output logic [clt_pkg::PIXEL_OUT_WIDTH-1:0] pixelOut,
  output logic pixelOutValid,
  input wire logic pixelOutReady
);

  typedef struct packed {
    logic [7:0] control;
    clt_pkg::clt_packet_e packet;
    logic [7:0] regAddress;
    logic [7:0] offset;
    logic readValid;
    logic [7:0] readData;
    logic stageValid;
    logic [clt_pkg::PIXEL_OUT_WIDTH-1:0] stagePixel;
  } clt_state_s;

  clt_state_s s;
  clt_state_s next_s;

  // Table ports.
  clt_pkg::clt_table_write_s writeRed;
  clt_pkg::clt_table_write_s writeGreen;
  clt_pkg::clt_table_write_s writeBlue;
  logic [7:0] lookRed;
  logic [7:0] lookGreen;
  logic [7:0] lookBlue;
  logic [7:0] backRed;
  logic [7:0] backGreen;
  logic [7:0] backBlue;
  logic [7:0] indexRed;
  logic [7:0] indexGreen;
  logic [7:0] indexBlue;
  logic [7:0] entryIndex;

  // Decoded control fields.
  logic programMode;
  logic redOn;
  logic greenOn;
  logic blueOn;
  logic isTable;

  // Pixel path handshakes.
  logic fifoInReady;
  logic takePixel;
  clt_pkg::clt_pixel_s translated;

  // Index into a table for one colour component.
  function automatic logic [7:0] tableIndex(
    input logic [7:0] component,
    input logic [1:0] width
  );
    logic [7:0] idx;
    idx = component;
    // Only six bits arrive in 3-channel mode; stray upper bits are
    // masked so a noisy input cannot reach entries above 0x3F.
    if (width == clt_pkg::WIDTH_THREE_CHANNEL) begin
      idx = component & clt_pkg::NARROW_INDEX_MASK;
    end
    return idx;
  endfunction : tableIndex

  // Place the components on the output word.
  function automatic logic [clt_pkg::PIXEL_OUT_WIDTH-1:0] packPixel(
    input clt_pkg::clt_pixel_s p
  );
    logic [clt_pkg::PIXEL_OUT_WIDTH-1:0] w;
    w = '0;
    w[5:0] = p.red[5:0];
    w[clt_pkg::OUT_GREEN_LOW +: 6] = p.green[5:0];
    w[clt_pkg::OUT_BLUE_LOW +: 6] = p.blue[5:0];
    w[clt_pkg::OUT_HSYNC] = p.hsync;
    w[clt_pkg::OUT_VSYNC] = p.vsync;
    w[clt_pkg::OUT_DATA_ENABLE] = p.dataEnable;
    w[clt_pkg::OUT_RED_HIGH +: 2] = p.red[7:6];
    w[clt_pkg::OUT_GREEN_HIGH +: 2] = p.green[7:6];
    w[clt_pkg::OUT_BLUE_HIGH +: 2] = p.blue[7:6];
    return w;
  endfunction : packPixel

  // Control fields as seen by the pixel path.
  assign programMode = s.control[clt_pkg::BIT_PROGRAM];
  assign redOn = s.control[clt_pkg::BIT_RED_ON];
  assign greenOn = s.control[clt_pkg::BIT_GREEN_ON];
  assign blueOn = s.control[clt_pkg::BIT_BLUE_ON];
  assign isTable = (s.regAddress == clt_pkg::ADDR_RED) ||
                   (s.regAddress == clt_pkg::ADDR_GREEN) ||
                   (s.regAddress == clt_pkg::ADDR_BLUE);

  // The pointer input is only read, never advanced; the offset
  // restarts with each packet and wraps after the 256th byte.
  assign entryIndex = tableStartPointer + s.offset;

  // Lookup indexes come straight from the incoming components.
  assign indexRed = tableIndex(pixelIn.red, busWidthSelect);
  assign indexGreen = tableIndex(pixelIn.green, busWidthSelect);
  assign indexBlue = tableIndex(pixelIn.blue, busWidthSelect);

  clt_table u_red (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tableWrite(writeRed),
    .lookIndex(indexRed),
    .lookData(lookRed),
    .readIndex(entryIndex),
    .readData(backRed)
  );

  clt_table u_green (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tableWrite(writeGreen),
    .lookIndex(indexGreen),
    .lookData(lookGreen),
    .readIndex(entryIndex),
    .readData(backGreen)
  );

  clt_table u_blue (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tableWrite(writeBlue),
    .lookIndex(indexBlue),
    .lookData(lookBlue),
    .readIndex(entryIndex),
    .readData(backBlue)
  );

  // Translation is held off entirely while tables are being loaded,
  // so a half-written table never reaches the screen.
  always_comb begin
    translated = pixelIn;
    if (!programMode) begin
      if (redOn) begin
        translated.red = lookRed;
      end
      if (greenOn) begin
        translated.green = lookGreen;
      end
      if (blueOn) begin
        translated.blue = lookBlue;
      end
    end
  end

  // A held stage empties into the FIFO; input stalls when it cannot.
  assign pixelInReady = !s.stageValid || fifoInReady;
  assign takePixel = pixelInValid && pixelInReady;

  // Packet handling, table writes and the pixel stage.
  always_comb begin
    next_s = s;
    next_s.readValid = 1'b0;
    writeRed = '0;
    writeGreen = '0;
    writeBlue = '0;
    writeRed.index = entryIndex;
    writeGreen.index = entryIndex;
    writeBlue.index = entryIndex;
    writeRed.data = byteData;
    writeGreen.data = byteData;
    writeBlue.data = byteData;
    if (packetStart.start) begin
      next_s.packet = packetStart.write ? clt_pkg::PKT_WRITE
                                        : clt_pkg::PKT_READ;
      next_s.regAddress = packetStart.regAddress;
      next_s.offset = 8'h00;
    end else if (packetEnd) begin
      next_s.packet = clt_pkg::PKT_IDLE;
    end else begin
      case (s.packet)
        clt_pkg::PKT_WRITE: begin
          if (byteValid && isTable) begin
            // Table bytes are dropped outside programming mode.
            if (programMode) begin
              case (s.regAddress)
                clt_pkg::ADDR_RED: writeRed.enable = 1'b1;
                clt_pkg::ADDR_GREEN: writeGreen.enable = 1'b1;
                default: writeBlue.enable = 1'b1;
              endcase
            end
            next_s.offset = s.offset + 8'h01;
          end else if (byteValid) begin
            if (s.regAddress == clt_pkg::ADDR_CONTROL) begin
              next_s.control = byteData;
            end
            next_s.regAddress = s.regAddress + 8'h01;
          end
        end
        clt_pkg::PKT_READ: begin
          if (readRequest && isTable) begin
            next_s.readValid = 1'b1;
            // Wraps at 256 so a zero byte count ends back at start.
            next_s.offset = s.offset + 8'h01;
            if (!programMode) begin
              next_s.readData = 8'h00;
            end else begin
              case (s.regAddress)
                clt_pkg::ADDR_RED: next_s.readData = backRed;
                clt_pkg::ADDR_GREEN: next_s.readData = backGreen;
                default: next_s.readData = backBlue;
              endcase
            end
          end else if (readRequest) begin
            next_s.readValid = 1'b1;
            next_s.readData = 8'h00;
            if (s.regAddress == clt_pkg::ADDR_CONTROL) begin
              next_s.readData = s.control;
            end
            next_s.regAddress = s.regAddress + 8'h01;
          end
        end
        default: begin
          next_s.packet = clt_pkg::PKT_IDLE;
        end
      endcase
    end
    // Sleep clears the enables so wake-up starts untranslated.
    if (sleepMode) begin
      next_s.control = clt_pkg::CONTROL_RESET;
    end
    // Pixel stage: load on accept, drop after the FIFO takes it.
    if (takePixel) begin
      next_s.stageValid = 1'b1;
      next_s.stagePixel = packPixel(translated);
    end else if (fifoInReady) begin
      next_s.stageValid = 1'b0;
    end
  end

  // Reset leaves every colour untranslated and no packet open.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s.control <= clt_pkg::CONTROL_RESET;
      s.packet <= clt_pkg::PKT_IDLE;
      s.regAddress <= 8'h00;
      s.offset <= 8'h00;
      s.readValid <= 1'b0;
      s.readData <= 8'h00;
      s.stageValid <= 1'b0;
      s.stagePixel <= '0;
    end else begin
      s <= next_s;
    end
  end

  // The FIFO absorbs output stalls; when full, the stage holds.
  clt_fifo #(
    .WIDTH(clt_pkg::PIXEL_OUT_WIDTH),
    .DEPTH(clt_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .inData(s.stagePixel),
    .inValid(s.stageValid),
    .inReady(fifoInReady),
    .outData(pixelOut),
    .outValid(pixelOutValid),
    .outReady(pixelOutReady)
  );

  // Readback and status come from flops.
  assign readValid = s.readValid;
  assign readData = s.readData;
  assign controlValue = s.control;

endmodule : color_lookup_translation

// ---- bench/clt_check_sva.sv ----
`timescale 1ns/10ps
// Port checker for the translation stage.
module clt_check (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic sleepMode,
  input wire clt_pkg::clt_packet_s packetStart,
  input wire logic packetEnd,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic readRequest,
  input wire logic readValid,
  input wire logic [7:0] readData,
  input wire logic [7:0] controlValue,
  input wire logic pixelInValid,
  input wire logic pixelInReady,
  input wire logic [clt_pkg::PIXEL_OUT_WIDTH-1:0] pixelOut,
  input wire logic pixelOutValid,
  input wire logic pixelOutReady
);
  logic ctlOpen;
  logic next_ctlOpen;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // A write packet to control stays open until its first byte lands.
  always_comb begin
    next_ctlOpen = ctlOpen;
    if (byteValid || packetEnd) begin
      next_ctlOpen = 1'b0;
    end
    if (packetStart.start) begin
      next_ctlOpen = packetStart.write &&
        packetStart.regAddress == clt_pkg::ADDR_CONTROL;
    end
  end
  // The tracker restarts with the design so stale packets never count.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctlOpen <= 1'b0;
    end else begin
      ctlOpen <= next_ctlOpen;
    end
  end
  a_ctl_write: assert property (
    ctlOpen && byteValid && !sleepMode |=> controlValue == $past(byteData))
    else $error("control write lost");
  a_ctl_cause: assert property (
    $changed(controlValue) |-> $past(byteValid) || $past(sleepMode))
    else $error("control changed alone");
  a_sleep_clear: assert property (
    sleepMode |=> controlValue == 8'h00)
    else $error("sleep kept enables");
  a_read_answer: assert property (
    readValid |-> $past(readRequest))
    else $error("read answer unasked");
  a_read_hold: assert property (
    !readValid |-> $stable(readData))
    else $error("read data moved");
  a_pixel_latency: assert property (
    pixelInValid && pixelInReady |-> ##2 pixelOutValid)
    else $error("pixel late");
  a_out_hold: assert property (
    pixelOutValid && !pixelOutReady |=> pixelOutValid && $stable(pixelOut))
    else $error("stalled pixel moved");
  a_pop_cause: assert property (
    $fell(pixelOutValid) |-> $past(pixelOutReady))
    else $error("pixel dropped");
  c_read: cover property (readValid);
  c_stall: cover property (!pixelInReady);
  c_sleep: cover property (sleepMode && controlValue != 8'h00);
endmodule : clt_check
bind color_lookup_translation clt_check clt_check_i (.sys_clk, .reset_n,
  .sleepMode, .packetStart, .packetEnd, .byteValid, .byteData,
  .readRequest, .readValid, .readData, .controlValue, .pixelInValid,
  .pixelInReady, .pixelOut, .pixelOutValid, .pixelOutReady);

// ---- bench/clt_host_model.sv ----
`timescale 1ns/10ps
// Controller that sends register packets over the control channel.
module clt_host_model (
  input wire logic sys_clk,
  output clt_pkg::clt_packet_s packetStart,
  output logic packetEnd,
  output logic byteValid,
  output logic [7:0] byteData,
  output logic readRequest,
  output logic [7:0] tableStartPointer,
  input wire logic readValid,
  input wire logic [7:0] readData
);
  // Idle levels from time zero.
  initial begin
    packetStart = '0;
    packetEnd = 1'b0;
    byteValid = 1'b0;
    byteData = 8'h00;
    readRequest = 1'b0;
    tableStartPointer = 8'h00;
  end
  // The pointer is loaded with the start and held through the packet.
  task automatic openPacket(input logic wr, input logic [7:0] addr,
    input logic [7:0] ptr);
    @(posedge sys_clk);
    packetStart <= '{1'b1, wr, addr};
    tableStartPointer <= ptr;
    @(posedge sys_clk);
    packetStart.start <= 1'b0;
  endtask : openPacket
  // Closes a packet one cycle after its last byte.
  task automatic closePacket();
    packetEnd <= 1'b1;
    @(posedge sys_clk);
    packetEnd <= 1'b0;
  endtask : closePacket
  // A zero count stands for a whole block of 256 bytes.
  task automatic writePacket(input logic [7:0] addr, input logic [7:0] ptr,
    input logic [7:0] count, input logic [7:0] q[$]);
    int n;
    n = (count == 8'h00) ? 256 : count;
    openPacket(1'b1, addr, ptr);
    for (int k = 0; k < n; k++) begin
      byteValid <= 1'b1;
      byteData <= q[k];
      @(posedge sys_clk);
    end
    byteValid <= 1'b0;
    byteData <= ~byteData;
    closePacket();
  endtask : writePacket
  // A missing answer is recorded as unknown so that it cannot match.
  task automatic readPacket(input logic [7:0] addr, input logic [7:0] ptr,
    input logic [7:0] count, output logic [7:0] q[$]);
    int n;
    n = (count == 8'h00) ? 256 : count;
    q = {};
    openPacket(1'b0, addr, ptr);
    for (int k = 0; k < n; k++) begin
      readRequest <= 1'b1;
      @(posedge sys_clk);
      readRequest <= 1'b0;
      @(negedge sys_clk);
      q.push_back(readValid === 1'b1 ? readData : 8'hXX);
      @(posedge sys_clk);
    end
    closePacket();
  endtask : readPacket
endmodule : clt_host_model

// ---- bench/color_lookup_translation_tb.sv ----
`timescale 1ns/10ps
// Programs the tables, then checks translated and buffered pixels.
module color_lookup_translation_tb;
  typedef struct {
    logic [7:0] ctl;
    logic [1:0] wsel;
    clt_pkg::clt_pixel_s pix;
  } clt_row_s;
  logic sys_clk, reset_n, sleepMode, packetEnd, byteValid, readRequest;
  logic readValid, pixelInValid, pixelInReady, pixelOutValid, pixelOutReady;
  logic [1:0] busWidthSelect;
  logic [7:0] tableStartPointer, byteData, readData, controlValue;
  logic [26:0] pixelOut;
  clt_pkg::clt_packet_s packetStart;
  clt_pkg::clt_pixel_s pixelIn, p;
  logic [7:0] expRed[256], expGreen[256], expBlue[256];
  logic [7:0] q[$], r[$];
  int nMismatch = 0;
  int nTests = 0;
  int cnt = 0;
  clt_row_s rows[6] = '{
    '{8'h07, 2'h1, {8'h12, 8'h34, 8'hFE, 3'b101}},
    '{8'h01, 2'h1, {8'hC3, 8'hC3, 8'hC3, 3'b010}},
    '{8'h0F, 2'h2, {8'hFF, 8'h00, 8'h80, 3'b111}},
    '{8'h06, 2'h0, {8'hC5, 8'h41, 8'hFF, 3'b001}},
    '{8'h07, 2'h2, {8'h00, 8'h3F, 8'h00, 3'b100}},
    '{8'h00, 2'h3, {8'hA5, 8'h5A, 8'h3C, 3'b011}}};
  color_lookup_translation color_lookup_translation_i (.sys_clk, .reset_n,
    .sleepMode, .busWidthSelect, .tableStartPointer, .packetStart,
    .packetEnd, .byteValid, .byteData, .readRequest, .readValid,
    .readData, .controlValue, .pixelIn, .pixelInValid, .pixelInReady,
    .pixelOut, .pixelOutValid, .pixelOutReady);
  clt_host_model clt_host_model_i (.sys_clk, .packetStart, .packetEnd,
    .byteValid, .byteData, .readRequest, .tableStartPointer, .readValid,
    .readData);
  // Free-running 50 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [26:0] exp, got);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Only enabled colours index their table, and not while programming.
  function automatic logic [26:0] expWord(input logic [7:0] ctl,
    input logic [1:0] wsel, input clt_pkg::clt_pixel_s x);
    logic [7:0] m, rd, gr, bl;
    m = (wsel == clt_pkg::WIDTH_THREE_CHANNEL) ? 8'h3F : 8'hFF;
    rd = (ctl[0] && !ctl[3]) ? expRed[x.red & m] : x.red;
    gr = (ctl[1] && !ctl[3]) ? expGreen[x.green & m] : x.green;
    bl = (ctl[2] && !ctl[3]) ? expBlue[x.blue & m] : x.blue;
    return {bl[7:6], gr[7:6], rd[7:6], x.dataEnable, x.vsync, x.hsync,
      bl[5:0], gr[5:0], rd[5:0]};
  endfunction : expWord
  task automatic setCtl(input logic [7:0] v);
    q = {v};
    clt_host_model_i.writePacket(clt_pkg::ADDR_CONTROL, 8'h00, 8'h01, q);
    check("control", v, controlValue);
  endtask : setCtl
  // Every table load is read back with the same address and count.
  task automatic loadTable(input logic [7:0] a, ptr, count);
    clt_host_model_i.writePacket(a, ptr, count, q);
    clt_host_model_i.readPacket(a, ptr, count, r);
    foreach (q[i]) check("readback", q[i], r[i]);
  endtask : loadTable
  task automatic sendPixel(input clt_pkg::clt_pixel_s x);
    @(posedge sys_clk);
    pixelIn <= x;
    pixelInValid <= 1'b1;
    @(posedge sys_clk);
    pixelInValid <= 1'b0;
    pixelIn <= ~x;
  endtask : sendPixel
  task automatic takePixel(input logic [26:0] exp);
    int w;
    w = 0;
    @(negedge sys_clk);
    while (pixelOutValid !== 1'b1 && w < 20) begin
      w++;
      @(negedge sys_clk);
    end
    check("pixelOut", exp, pixelOut);
    @(posedge sys_clk);
    pixelOutReady <= 1'b1;
    @(posedge sys_clk);
    pixelOutReady <= 1'b0;
  endtask : takePixel
  // Cuts a hang short; the whole sequence needs about 1150 cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    nMismatch++;
    conclude();
  end
  // Main sequence: reset, program, pixel rows, then the awkward cases.
  initial begin
    reset_n = 1'b0;
    sleepMode = 1'b0;
    busWidthSelect = 2'h1;
    pixelIn = '0;
    pixelInValid = 1'b0;
    pixelOutReady = 1'b0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    check("ctl reset", 8'h00, controlValue);
    check("out reset", 1'b0, pixelOutValid);
    setCtl(8'h08);
    // The control write left its byte in the queue; start the table empty.
    q = {};
    for (int i = 0; i < 256; i++) begin
      q.push_back(8'(i) ^ 8'h5A);
      expRed[i] = 8'(i) ^ 8'h5A;
    end
    loadTable(clt_pkg::ADDR_RED, 8'h00, 8'h00);
    q = {};
    for (int i = 0; i < 64; i++) begin
      q.push_back(8'(3 * i) & 8'h3F);
      expGreen[i] = 8'(3 * i) & 8'h3F;
    end
    loadTable(clt_pkg::ADDR_GREEN, 8'h00, 8'h40);
    q = {8'h11, 8'h22, 8'h33};
    expBlue[254] = 8'h11;
    expBlue[255] = 8'h22;
    expBlue[0] = 8'h33;
    loadTable(clt_pkg::ADDR_BLUE, 8'hFE, 8'h03);
    q = {8'h44};
    expBlue[63] = 8'h44;
    loadTable(clt_pkg::ADDR_BLUE, 8'h3F, 8'h01);
    foreach (rows[i]) begin
      setCtl(rows[i].ctl);
      busWidthSelect <= rows[i].wsel;
      sendPixel(rows[i].pix);
      takePixel(expWord(rows[i].ctl, rows[i].wsel, rows[i].pix));
    end
    setCtl(8'h07);
    clt_host_model_i.readPacket(clt_pkg::ADDR_RED, 8'h00, 8'h01, r);
    check("locked read", 8'h00, r[0]);
    clt_host_model_i.readPacket(8'h10, 8'h00, 8'h01, r);
    check("unmapped", 8'h00, r[0]);
    sleepMode <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sleepMode <= 1'b0;
    @(negedge sys_clk);
    check("sleep", 8'h00, controlValue);
    // Stall the far side and push until the stage refuses.
    @(posedge sys_clk);
    pixelIn <= '0;
    pixelInValid <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      @(negedge sys_clk);
      if (pixelInReady) begin
        cnt++;
      end
      @(posedge sys_clk);
      pixelIn.red <= 8'(cnt);
    end
    pixelInValid <= 1'b0;
    check("fill", 27'(clt_pkg::FIFO_DEPTH + 1), 27'(cnt));
    for (int k = 0; k < cnt; k++) begin
      p = '0;
      p.red = 8'(k);
      takePixel(expWord(8'h00, 2'h1, p));
    end
    conclude();
  end
endmodule : color_lookup_translation_tb
